/* File: design/lpc_defines.vh */
// How it works
// R1 - Control bit 0 enables block and interrupts
// R2 - One interrupt output ORs enabled channel events
// R3 - Control bits 4..1 enable channel 3..0 interrupts
// R4 - Control bit 5: channel 0 rising or falling
// R5 - Control bit 6: channel 1 rising or falling
// R6 - Control bit 7: shared edge for channels 2,3
// R7 - Status bits 3..0 show live comparator outputs
// R8 - Status bits 7..4 sticky per-channel event flags
// R9 - Reading status clears all sticky flags
// R10 - Software sets edges and enable before irq enables
// R11 - Pulses of 500 ns or more detected
// R12 - All control and flags reset to zero
// R13 - Inputs synchronised; event beats simultaneous read-clear
`ifndef LPC_DEFINES_VH
`define LPC_DEFINES_VH
`define LPC_ADDR_STATUS 4'h0
`define LPC_ADDR_CONTROL 4'h4
`define LPC_ADDR_MASK 4'h8
`define LPC_ADDR_PENDING 4'hC
`define LPC_CTRL_ENABLE 0
`define LPC_CTRL_IRQ_EN_LO 1
`define LPC_CTRL_EDGE_CH0 5
`define LPC_CTRL_EDGE_CH1 6
`define LPC_CTRL_EDGE_CH23 7
`define LPC_STAT_FLAG_LO 4
`define LPC_CTRL_RESET 8'h00
`define LPC_STAT_RESET 4'h0
`define LPC_MASK_RESET 1'h0
`define LPC_PULSE_NS 500
`define LPC_CLK_NS 10
`define LPC_PULSE_CYCLES (`LPC_PULSE_NS / `LPC_CLK_NS)
`define LPC_RESP_OKAY 2'h0
`define LPC_RESP_SLVERR 2'h2
`endif

/* File: design/lpc_edge_detect.v */
`timescale 1ns/10ps
`include "lpc_defines.vh"
module lpc_edge_detect (
  input wire aclk,
  input wire aresetn,
  input wire async_in,
  input wire enable,
  input wire rising_sel,
  output reg level,
  output reg event_pulse
);
  reg meta;
  reg sync;
  reg sync_d;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      sync_d <= 1'b0;
      level <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      meta <= async_in; // R13
      sync <= meta;
      sync_d <= sync;
      level <= sync; // R7
      // One-cycle sampling at 10 ns catches any 500 ns pulse
      if (enable) begin // R1 R11
        event_pulse <= rising_sel ? (sync & ~sync_d) : (~sync & sync_d);
      end else begin
        event_pulse <= 1'b0;
      end
    end
  end
endmodule

/* File: design/lpc_comparator_irq.v */
`timescale 1ns/10ps
`include "lpc_defines.vh"
module lpc_comparator_irq (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] live_compare_result,
  output reg comparator_power_enable,
  output reg irq,
  input wire [3:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg [7:0] comparator_control;
  reg [3:0] sticky_irq_flag;
  reg mask;
  reg [3:0] aw_addr;
  reg aw_held;
  reg [7:0] w_data;
  reg w_lane0;
  reg w_held;
  wire [3:0] live_level;
  wire [3:0] chan_event;
  wire [3:0] channel_irq_enable;
  wire [3:0] channel_edge_select;
  wire block_enable;
  wire status_read;
  wire do_write;
  wire [3:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_lane0;
  wire [3:0] next_sticky;
  wire [3:0] pending;
  reg next_aw_held;
  reg [3:0] next_aw_addr;
  reg next_w_held;
  reg [7:0] next_w_data;
  reg next_w_lane0;
  reg next_awready;
  reg next_wready;
  reg next_bvalid;
  reg [1:0] next_bresp;
  reg next_arready;
  reg next_rvalid;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  reg [7:0] next_control;
  reg next_mask;
  reg next_irq;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire b_done;
  wire r_done;
  wire [3:0] wr_sel;
  wire [3:0] rd_sel;

  function known_addr;
    input [3:0] a;
    begin
      known_addr = (a == `LPC_ADDR_STATUS) || (a == `LPC_ADDR_CONTROL) ||
        (a == `LPC_ADDR_MASK) || (a == `LPC_ADDR_PENDING);
    end
  endfunction

  assign block_enable = comparator_control[`LPC_CTRL_ENABLE];
  assign channel_irq_enable = comparator_control[4:1]; // R3
  assign channel_edge_select = {
    comparator_control[`LPC_CTRL_EDGE_CH23], // R6
    comparator_control[`LPC_CTRL_EDGE_CH23], // R6
    comparator_control[`LPC_CTRL_EDGE_CH1], // R5
    comparator_control[`LPC_CTRL_EDGE_CH0] // R4
  };

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      lpc_edge_detect u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(live_compare_result[g]),
        .enable(block_enable),
        .rising_sel(channel_edge_select[g]),
        .level(live_level[g]),
        .event_pulse(chan_event[g])
      );
    end
  endgenerate

  // Write channel: address and data may arrive in either order
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata[7:0];
  assign wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
  assign do_write = (aw_held | (s_axi_awvalid & s_axi_awready)) &
    (w_held | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;

  assign status_read = s_axi_arvalid & s_axi_arready &
    (s_axi_araddr == `LPC_ADDR_STATUS);
  // New event wins over the read-clear
  assign next_sticky = (status_read ? 4'h0 : sticky_irq_flag) |
    (chan_event & channel_irq_enable); // R8 R9 R13
  assign pending = sticky_irq_flag & channel_irq_enable;

  // One-hot register select, shared by the write and read sides
  function [3:0] reg_select;
    input [3:0] a;
    begin
      case (a)
        `LPC_ADDR_STATUS: reg_select = 4'h1;
        `LPC_ADDR_CONTROL: reg_select = 4'h2;
        `LPC_ADDR_MASK: reg_select = 4'h4;
        `LPC_ADDR_PENDING: reg_select = 4'h8;
        default: reg_select = 4'h0;
      endcase
    end
  endfunction

  // Read data mux; unmapped offsets read as zero
  function [31:0] read_word;
    input [3:0] sel;
    input [7:0] status;
    input [7:0] control;
    input mask_bit;
    input [3:0] pend;
    begin
      read_word = 32'h00000000;
      if (sel[0]) begin
        read_word = {24'h000000, status};
      end
      if (sel[1]) begin
        read_word = {24'h000000, control};
      end
      if (sel[2]) begin
        read_word = {31'h00000000, mask_bit};
      end
      if (sel[3]) begin
        read_word = {28'h0000000, pend};
      end
    end
  endfunction

  // Handshakes completing at this edge
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign b_done = s_axi_bvalid & s_axi_bready;
  assign r_done = s_axi_rvalid & s_axi_rready;
  assign wr_sel = reg_select(wr_addr);
  assign rd_sel = reg_select(s_axi_araddr);

  // Address and data are held until both have arrived
  always @* begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_awready = ~aw_held & ~aw_take & ~s_axi_bvalid;
    next_wready = ~w_held & ~w_take & ~s_axi_bvalid;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (aw_take) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_awready = 1'b0;
      next_wready = 1'b0;
      next_bvalid = 1'b1;
      if (known_addr(wr_addr)) begin
        next_bresp = `LPC_RESP_OKAY;
      end else begin
        next_bresp = `LPC_RESP_SLVERR;
      end
    end else if (b_done) begin
      next_bvalid = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPC_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Only byte lane 0 carries register bits
  always @* begin
    next_control = comparator_control;
    next_mask = mask;
    if (do_write & wr_lane0 & wr_sel[1]) begin
      next_control = wr_data;
    end
    if (do_write & wr_lane0 & wr_sel[2]) begin
      next_mask = wr_data[0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      comparator_control <= `LPC_CTRL_RESET; // R12
      mask <= `LPC_MASK_RESET;
    end else begin
      comparator_control <= next_control;
      mask <= next_mask;
    end
  end

  // Status data are captured before the read-clear lands
  always @* begin
    next_arready = ~s_axi_rvalid & ~ar_take;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (ar_take) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = read_word(rd_sel, {sticky_irq_flag, live_level},
        comparator_control, mask, pending); // R7 R8
      if (known_addr(s_axi_araddr)) begin
        next_rresp = `LPC_RESP_OKAY;
      end else begin
        next_rresp = `LPC_RESP_SLVERR;
      end
    end else if (r_done) begin
      next_rvalid = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LPC_RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // No interrupt leaves the block while it is disabled
  always @* begin
    next_irq = 1'b0;
    if (block_enable & mask) begin // R1
      next_irq = |(next_sticky & channel_irq_enable); // R2
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sticky_irq_flag <= `LPC_STAT_RESET; // R12
      irq <= 1'b0;
      comparator_power_enable <= 1'b0;
    end else begin
      sticky_irq_flag <= next_sticky;
      comparator_power_enable <= block_enable; // R1
      irq <= next_irq;
    end
  end
endmodule

/* File: sim/lpc_cmp_model.sv */
`timescale 1ns/10ps
module lpc_cmp_model (
  input wire aclk,
  output logic [3:0] cmp
);
  initial cmp = 4'h0;
  // Level held until the next call, so any pulse is as long as asked
  task set(input int ch, input bit v);
    @(posedge aclk);
    cmp[ch] <= v;
  endtask
endmodule

/* File: sim/lpc_comparator_irq_chk.sv */
`timescale 1ns/10ps
module lpc_comparator_irq_chk (
  input wire aclk,
  input wire aresetn,
  input wire comparator_power_enable,
  input wire irq,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_ans: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("no read answer");
  a_write_ans: assert property (s_w_take |=> s_axi_bvalid)
    else $error("no write answer");
  a_busy_refuse: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("upper rdata set");
  a_irq_enabled: assert property ($rose(irq) |-> comparator_power_enable)
    else $error("irq while disabled");
  a_read_clear: assert property ((s_ar_take and s_axi_araddr == 4'h0)
    |-> ##[1:3] !irq) else $error("irq kept after read");
  a_irq_power: assert property (irq |-> comparator_power_enable)
    else $error("irq with block off");
endmodule
bind lpc_comparator_irq lpc_comparator_irq_chk u_chk (.*);

/* File: sim/lpc_comparator_irq_tb_top.sv */
`timescale 1ns/10ps
module lpc_comparator_irq_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, comparator_power_enable, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, live_compare_result;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] last_resp;
  logic [7:0] v, c;
  int num_errors = 0, n_tests = 0;
  lpc_comparator_irq DUT (.*);
  lpc_cmp_model M (.aclk(aclk), .cmp(live_compare_result));
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  task chk(input string n, input [7:0] s, input [7:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    last_resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input [3:0] a, output [7:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    last_resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task hold(input int ch, input bit b);
    M.set(ch, b);
    repeat (50) @(posedge aclk);
  endtask
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(0, v);
    chk("status", v, 8'h00);
    rd(4, v);
    chk("control", v, 8'h00);
    chk("irq", irq, 0);
    wr(0, 8'hFF);
    chk("bresp", last_resp, 0);
    rd(0, v);
    chk("rresp", last_resp, 0);
    chk("status", v, 8'h00);
    $display("reset test done");
    wr(8, 1);
    rd(8, v);
    chk("mask", v, 8'h01);
    for (int ch = 0; ch < 4; ch++)
      for (int r = 0; r < 2; r++) begin
        c = 8'h01 | (r << (ch < 2 ? 5 + ch : 7));
        wr(4, c);
        c = c | (2 << ch);
        wr(4, c);
        rd(4, v);
        chk("control", v, c);
        chk("power", comparator_power_enable, 1);
        hold(ch, 1);
        chk("irq", irq, r);
        rd(12, v);
        chk("pending", v, r ? 8'h01 << ch : 8'h00);
        rd(0, v);
        chk("status", v, 8'h01 << ch | (r ? 8'h10 << ch : 0));
        hold(ch, 0);
        chk("irq", irq, 1 - r);
        rd(0, v);
        chk("status", v, r ? 8'h00 : 8'h10 << ch);
      end
    $display("edge test done");
    wr(8, 0);
    wr(4, 8'h21);
    wr(4, 8'h23);
    hold(0, 1);
    chk("irq", irq, 0);
    rd(12, v);
    chk("pending", v, 8'h01);
    wr(8, 1);
    @(posedge aclk);
    chk("irq", irq, 1);
    $display("mask test done");
    wr(4, 8'h1E);
    @(posedge aclk);
    chk("power", comparator_power_enable, 0);
    chk("irq", irq, 0);
    rd(0, v);
    chk("status", v, 8'h11);
    hold(0, 0);
    hold(0, 1);
    hold(0, 0);
    rd(0, v);
    chk("status", v, 8'h00);
    chk("irq", irq, 0);
    $display("disable test done");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(4, v);
    chk("control", v, 8'h00);
    rd(8, v);
    chk("mask", v, 8'h00);
    $display("second reset test done");
    give_verdict;
  end
endmodule
